/* rtl/lin_slave_controller.sv */
`timescale 1ns/1ps
module lin_slave_controller #(
    parameter int unsigned IDLE_CYCLES = lin_slave_pkg::IDLE_CYC
) (
    input  logic        sys_clk_i,
    input  logic        sys_rst_i,
    input  logic        controller_enable_i,
    input  logic        sleep_select_i,
    input  logic        interrupt_enable_bit_i,
    input  logic        checksum_type_select_i,
    input  logic        response_direction_i,
    input  logic        length_from_identifier_i,
    input  logic        readback_disable_i,
    input  logic [1:0]  pin_mode_select_i,
    input  logic        dma_channel_select_i,
    input  logic [2:0]  dma_peripheral_select0_i,
    input  logic [2:0]  dma_peripheral_select1_i,
    input  logic [3:0]  response_size_i,
    input  logic        header_acknowledge_i,
    input  logic        frame_stop_i,
    input  logic        wake_signal_bit_i,
    input  logic        error_summary_clear_i,
    input  logic        header_flag_clear_i,
    input  logic        response_flag_clear_i,
    input  logic        idle_flag_clear_i,
    input  logic        wake_flag_clear_i,
    input  logic        p01_i,
    input  logic        p11_i,
    input  logic [1:0]  dma_ack_i,
    input  logic [7:0]  dma_rdata_i,
    output logic        header_received_flag_o,
    output logic        response_complete_flag_o,
    output logic        bus_idle_flag_o,
    output logic        wake_signal_bit_o,
    output logic        readback_error_flag_o,
    output logic        sync_error_flag_o,
    output logic        identifier_error_flag_o,
    output logic        data_checksum_error_flag_o,
    output logic        error_summary_o,
    output logic        abort_flag_o,
    output logic        bus_active_o,
    output logic [5:0]  received_identifier_o,
    output logic [15:0] lin_baud_o,
    output logic        irq_o,
    output logic [1:0]  dma_req_o,
    output logic        dma_write_o,
    output logic [7:0]  dma_wdata_o,
    output logic        p00_o,
    output logic        p00_oe_o,
    output logic        p10_o,
    output logic        p10_oe_o,
    output logic        p11_o,
    output logic        p11_oe_o
);
    import lin_slave_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Carry-folding add used by both checksum generation and checking
    function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

    function automatic logic pid_ok(input logic [7:0] p);
        return (p[6] == (p[0] ^ p[1] ^ p[2] ^ p[4])) && (p[7] == !(p[1] ^ p[3] ^ p[4] ^ p[5]));
    endfunction

    // Cycles in n bit times of the current rate
    function automatic logic [CNT_W-1:0] bit_span(input logic [15:0] b, input logic [4:0] n);
        return ({5'h00, b} + 21'h000001) * {16'h0000, n};
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers and receive selection
    // ----------------------------------------------------------------
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic       rx_prev_q;
    logic       rx;
    logic       fall;
    logic       rise;

    // Reserved pin mode leaves the receiver on a recessive level
    always_comb begin
        unique case (pin_mode_select_i)
            PINS_P0_2W: rx = sync2_q[0];
            PINS_P1_2W: rx = sync2_q[1];
            PINS_P1_1W: rx = sync2_q[1];
            default:    rx = 1'b1;
        endcase
        fall = rx_prev_q & ~rx;
        rise = ~rx_prev_q & rx;
    end

    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    state_t           st_q,    st_d;
    logic [CNT_W-1:0] cnt_q,   cnt_d;
    logic [3:0]       bitn_q,  bitn_d;
    logic [7:0]       sh_q,    sh_d;
    logic [4:0]       idx_q,   idx_d;
    logic [3:0]       len_q,   len_d;
    logic [7:0]       sum_q,   sum_d;
    logic             dir_q,   dir_d;
    logic [15:0]      bit_q,   bit_d;
    logic [2:0]       falls_q, falls_d;
    logic [7:0]       pid_q,   pid_d;
    logic [1:0]       req_q,   req_d;
    logic [7:0]       wdata_q, wdata_d;
    logic             sending, txl, byte_done, frame_bad, got, lin_dma_ok;
    logic             new_hdr, hdr_set, done_set, pe_set, sy_set, ck_set, rb_set;
    logic             wk_set, ab_set, err_set;
    logic [1:0]       req_one;

    always_comb begin
        st_d = st_q;       cnt_d = cnt_q;   bitn_d = bitn_q;   sh_d = sh_q;
        idx_d = idx_q;     len_d = len_q;   sum_d = sum_q;     dir_d = dir_q;
        bit_d = bit_q;     falls_d = falls_q; pid_d = pid_q;   wdata_d = wdata_q;
        req_d = req_q & ~dma_ack_i;
        got = |(req_q & dma_ack_i);
        req_one = dma_channel_select_i ? 2'h2 : 2'h1;
        lin_dma_ok = (dma_channel_select_i ? dma_peripheral_select1_i[2:1]
                                           : dma_peripheral_select0_i[2:1]) == DMA_LIN_CODE;
        sending = (st_q == ST_RESP) && (dir_q == DIR_SEND);
        new_hdr = 1'b0; hdr_set = 1'b0; done_set = 1'b0; pe_set = 1'b0;
        sy_set = 1'b0;  ck_set = 1'b0;  rb_set = 1'b0;   wk_set = 1'b0;
        ab_set = 1'b0;  byte_done = 1'b0; frame_bad = 1'b0;
        // Transmit level: start bit, data bits from the shifter, stop high
        txl = !((st_q == ST_WAKE) || (sending && ((bitn_q == BIT_START)
              || (bitn_q > BIT_START && bitn_q < BIT_STOP && !sh_q[0]))));

        // Shared byte timing: receive samples mid-bit, send steps at bit end
        if (st_q == ST_PID || st_q == ST_RESP) begin
            if (bitn_q == 4'h0) begin
                if (!sending && fall) begin
                    bitn_d = BIT_START;
                    cnt_d = CNT_W'(bit_q >> 1);
                end
            end else if (cnt_q == '0) begin
                cnt_d = CNT_W'(bit_q);
                bitn_d = bitn_q + 4'h1;
                if (!sending && bitn_q == BIT_START && rx)
                    bitn_d = 4'h0; // Glitch, not a real start bit
                if (bitn_q > BIT_START && bitn_q < BIT_STOP)
                    sh_d = {sending ? 1'b1 : rx, sh_q[7:1]};
                if (bitn_q == BIT_STOP) begin
                    bitn_d = 4'h0;
                    byte_done = 1'b1;
                    frame_bad = !sending && !rx;
                end
            end else begin
                cnt_d = cnt_q - CNT_W'(1);
                if (sending && cnt_q == CNT_W'(bit_q >> 1) && !readback_disable_i
                    && rx != txl)
                    rb_set = 1'b1;
            end
        end

        unique case (st_q)
            // Nothing is sent unprompted; only a break opens a frame
            ST_IDLE: begin
                cnt_d = rx ? '0 : (&cnt_q ? cnt_q : cnt_q + CNT_W'(1));
                if (rise && sleep_select_i && cnt_q >= CNT_W'(WAKE_RX_CYC)) begin
                    wk_set = 1'b1;
                end else if (rise && !sleep_select_i
                             && cnt_q >= bit_span(bit_q, BREAK_BITS)) begin
                    st_d = ST_SYNC;
                    cnt_d = '0;
                    falls_d = 3'h0;
                    new_hdr = 1'b1;
                end
                if (wake_signal_bit_i) begin
                    st_d = ST_WAKE;
                    cnt_d = CNT_W'(WAKE_TX_CYC - 1);
                end
            end
            // Eight bit times lie between the first and fifth falling edge
            ST_SYNC: begin
                cnt_d = cnt_q + CNT_W'(1);
                if (fall) begin
                    falls_d = falls_q + 3'h1;
                    if (falls_q == 3'h0)
                        cnt_d = '0;
                    if (falls_q == SYNC_FALLS) begin
                        if (cnt_q[CNT_W-1:4] == '0) begin
                            sy_set = 1'b1; // Premature edges, rate too high
                        end else begin
                            bit_d = 16'((cnt_q + CNT_W'(1)) >> 3) - 16'h0001;
                            st_d = ST_PID;
                            bitn_d = 4'h0;
                        end
                    end
                end else if (cnt_q >= bit_span(bit_q, SYNC_TO_BITS)) begin
                    sy_set = 1'b1;
                end
            end
            ST_PID: begin
                if (byte_done) begin
                    pid_d = sh_q;
                    if (frame_bad || !pid_ok(sh_q)) begin
                        pe_set = 1'b1;
                    end else begin
                        hdr_set = 1'b1;
                        st_d = ST_WAIT;
                    end
                end
            end
            // Acknowledge is held off until the chosen channel serves LIN
            ST_WAIT: begin
                if (header_acknowledge_i && lin_dma_ok) begin
                    st_d = ST_RESP;
                    dir_d = response_direction_i;
                    len_d = length_from_identifier_i ? (!pid_q[5] ? LEN_ID0X :
                            (pid_q[4] ? LEN_ID11 : LEN_ID10)) : response_size_i;
                    idx_d = 5'h00;
                    sum_d = (checksum_type_select_i == CSUM_ENH) ? pid_q : 8'h00;
                    bitn_d = 4'h0;
                end else if (fall) begin
                    st_d = ST_IDLE; // Unanswered header, bus moved on
                    cnt_d = '0;
                end
            end
            ST_RESP: begin
                if (sending && bitn_q == 4'h0) begin
                    if (idx_q < {1'b0, len_q}) begin
                        if (got) begin
                            sh_d = dma_rdata_i;
                            sum_d = csum_add(sum_q, dma_rdata_i);
                            idx_d = idx_q + 5'h01;
                            bitn_d = BIT_START;
                            cnt_d = CNT_W'(bit_q);
                        end else if (req_q == 2'h0) begin
                            req_d = req_one;
                        end
                    end else if (idx_q == {1'b0, len_q}) begin
                        sh_d = ~sum_q; // Checksum byte goes out last
                        idx_d = idx_q + 5'h01;
                        bitn_d = BIT_START;
                        cnt_d = CNT_W'(bit_q);
                    end
                end
                if (byte_done) begin
                    if (sending) begin
                        if (idx_q > {1'b0, len_q}) begin
                            done_set = 1'b1;
                            st_d = ST_IDLE;
                        end
                    end else if (frame_bad) begin
                        ck_set = 1'b1;
                    end else if (idx_q < {1'b0, len_q}) begin
                        wdata_d = sh_q;
                        req_d = req_one;
                        sum_d = csum_add(sum_q, sh_q);
                        idx_d = idx_q + 5'h01;
                    end else if (csum_add(sum_q, sh_q) != CSUM_GOOD) begin
                        ck_set = 1'b1;
                    end else begin
                        done_set = 1'b1;
                        st_d = ST_IDLE;
                    end
                end
            end
            // Clear the count on exit so our own wake-up is not taken for a break
            ST_WAKE: begin
                cnt_d = cnt_q - CNT_W'(1);
                if (cnt_q == '0) begin
                    st_d = ST_IDLE;
                    cnt_d = '0;
                end
            end
        endcase

        // Any error ends the frame at once; stop and disable do too
        err_set = pe_set | sy_set | ck_set | rb_set;
        if (frame_stop_i && st_q != ST_IDLE && st_q != ST_WAKE) begin
            ab_set = 1'b1;
        end
        if (err_set || ab_set || !controller_enable_i) begin
            st_d = ST_IDLE;
            cnt_d = '0;
            bitn_d = 4'h0;
            req_d = 2'h0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= ST_IDLE;  cnt_q <= '0;       bitn_q <= 4'h0;  sh_q <= 8'h00;
            idx_q <= 5'h00;   len_q <= 4'h0;     sum_q <= 8'h00;  dir_q <= 1'b0;
            bit_q <= BAUD_RST; falls_q <= 3'h0;  pid_q <= 8'h00;  req_q <= 2'h0;
            wdata_q <= 8'h00; sync1_q <= 2'h3;   sync2_q <= 2'h3; rx_prev_q <= 1'b1;
        end else begin
            st_q <= st_d;     cnt_q <= cnt_d;     bitn_q <= bitn_d; sh_q <= sh_d;
            idx_q <= idx_d;   len_q <= len_d;     sum_q <= sum_d;   dir_q <= dir_d;
            bit_q <= bit_d;   falls_q <= falls_d; pid_q <= pid_d;   req_q <= req_d;
            wdata_q <= wdata_d; sync1_q <= {p11_i, p01_i}; sync2_q <= sync1_q;
            rx_prev_q <= rx;
        end
    end

    // ----------------------------------------------------------------
    // Flags, idle timer, interrupt and pins
    // ----------------------------------------------------------------
    logic        hdr_q, done_q, idle_q, wake_q, rb_q, sy_q, pe_q, ck_q, esum_q, ab_q;
    logic        hdr_d, done_d, idle_d, wake_d, rb_d, sy_d, pe_d, ck_d, esum_d, ab_d;
    logic        irq_q, irq_d, act_q, act_d;
    logic [31:0] idle_cnt_q, idle_cnt_d;
    logic [5:0]  pins_q, pins_d;
    logic        eclr;

    // Every set term is ORed in last so a same-cycle event beats its clear
    always_comb begin
        eclr = new_hdr | error_summary_clear_i;
        hdr_d  = (hdr_q & ~(header_flag_clear_i | header_acknowledge_i | new_hdr)) | hdr_set;
        done_d = (done_q & ~(response_flag_clear_i | new_hdr)) | done_set;
        wake_d = (wake_q & ~wake_flag_clear_i) | wk_set;
        pe_d   = (pe_q & ~eclr) | pe_set;
        sy_d   = (sy_q & ~eclr) | sy_set;
        ck_d   = (ck_q & ~eclr) | ck_set;
        rb_d   = (rb_q & ~eclr) | rb_set;
        esum_d = (esum_q & ~error_summary_clear_i) | err_set;
        ab_d   = (ab_q & ~new_hdr) | ab_set;
        // Idle timer runs only on a quiet, recessive bus and saturates
        idle_cnt_d = (!rx || st_q != ST_IDLE || !controller_enable_i) ? 32'h0000_0000
                   : (idle_cnt_q == 32'(IDLE_CYCLES) ? idle_cnt_q : idle_cnt_q + 32'h0000_0001);
        idle_d = (idle_q & ~idle_flag_clear_i)
               | (idle_cnt_q == 32'(IDLE_CYCLES - 1) && !sleep_select_i);
        irq_d = interrupt_enable_bit_i & (idle_d | wake_d | hdr_d | done_d | esum_d);
        act_d = (st_d == ST_SYNC) || (st_d == ST_PID) || (st_d == ST_RESP);
        // Two-wire pins push-pull; single wire only pulls the bus low
        pins_d = {txl, pin_mode_select_i == PINS_P0_2W,
                  txl, pin_mode_select_i == PINS_P1_2W,
                  1'b0, pin_mode_select_i == PINS_P1_1W && !txl};
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hdr_q <= 1'b0; done_q <= 1'b0; idle_q <= 1'b0; wake_q <= 1'b0; rb_q <= 1'b0;
            sy_q <= 1'b0;  pe_q <= 1'b0;   ck_q <= 1'b0;   esum_q <= 1'b0; ab_q <= 1'b0;
            irq_q <= 1'b0; act_q <= 1'b0;  idle_cnt_q <= 32'h0000_0000;
            pins_q <= 6'h00;
        end else begin
            hdr_q <= hdr_d; done_q <= done_d; idle_q <= idle_d; wake_q <= wake_d;
            rb_q <= rb_d;   sy_q <= sy_d;     pe_q <= pe_d;     ck_q <= ck_d;
            esum_q <= esum_d; ab_q <= ab_d;   irq_q <= irq_d;   act_q <= act_d;
            idle_cnt_q <= idle_cnt_d;
            pins_q <= pins_d;
        end
    end

    assign header_received_flag_o     = hdr_q;
    assign response_complete_flag_o   = done_q;
    assign bus_idle_flag_o            = idle_q;
    assign wake_signal_bit_o          = wake_q;
    assign readback_error_flag_o      = rb_q;
    assign sync_error_flag_o          = sy_q;
    assign identifier_error_flag_o    = pe_q;
    assign data_checksum_error_flag_o = ck_q;
    assign error_summary_o            = esum_q;
    assign abort_flag_o               = ab_q;
    assign bus_active_o               = act_q;
    assign received_identifier_o      = pid_q[5:0];
    assign lin_baud_o                 = bit_q;
    assign irq_o                      = irq_q;
    assign dma_req_o                  = req_q;
    assign dma_write_o                = dir_q;
    assign dma_wdata_o                = wdata_q;
    assign {p00_o, p00_oe_o, p10_o, p10_oe_o, p11_o, p11_oe_o} = pins_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    pid_error_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(pe_q) |-> !$rose(hdr_q) && st_q == ST_IDLE)
        else $error("identifier error raised with header flag");
    hdr_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        header_acknowledge_i && !hdr_set |=> !hdr_q)
        else $error("header flag survived acknowledge");
    done_set_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        done_set |=> response_complete_flag_o && st_q == ST_IDLE)
        else $error("response flag not set at frame end");
    idle_sleep_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(idle_q) |-> !$past(sleep_select_i) && $past(idle_cnt_q) == 32'(IDLE_CYCLES - 1))
        else $error("idle flag raised in sleep or early");
    irq_gate_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !$past(interrupt_enable_bit_i) |-> !irq_o)
        else $error("interrupt with enable clear");
    err_stop_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        err_set |=> error_summary_o && st_q == ST_IDLE && dma_req_o == 2'h0)
        else $error("error did not stop the frame");
    stop_abort_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        frame_stop_i && st_q inside {ST_SYNC, ST_PID, ST_WAIT, ST_RESP}
        |=> abort_flag_o && st_q == ST_IDLE)
        else $error("stop did not abort the frame");
    sleep_nohdr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (sleep_select_i || !controller_enable_i) && st_q == ST_IDLE |=> st_q != ST_SYNC)
        else $error("header search while asleep or disabled");
    wake_drive_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st_q == ST_IDLE && controller_enable_i && wake_signal_bit_i
        |=> st_q == ST_WAKE ##1 !txl)
        else $error("wake request not driven");

endmodule

/* rtl/lin_slave_pkg.sv */
package lin_slave_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned CLK_MHZ     = CLK_HZ / 1_000_000;
    localparam int unsigned IDLE_TIME_S = 4;
    localparam int unsigned IDLE_CYC    = IDLE_TIME_S * CLK_HZ;
    localparam int unsigned WAKE_TX_US  = 250;
    localparam int unsigned WAKE_TX_CYC = WAKE_TX_US * CLK_MHZ;
    localparam int unsigned WAKE_RX_US  = 150;
    localparam int unsigned WAKE_RX_CYC = WAKE_RX_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Frame timing in bit times of the adapted rate
    // ----------------------------------------------------------------
    localparam int unsigned CNT_W        = 21;
    localparam logic [4:0]  BREAK_BITS   = 5'h0B;
    localparam logic [4:0]  SYNC_TO_BITS = 5'h10;
    localparam logic [2:0]  SYNC_FALLS   = 3'h4;
    localparam logic [15:0] BAUD_RST     = 16'h04AF;
    localparam logic [3:0]  BIT_START    = 4'h1;
    localparam logic [3:0]  BIT_STOP     = 4'hA;

    // ----------------------------------------------------------------
    // Configuration codes
    // ----------------------------------------------------------------
    localparam logic [1:0] PINS_P0_2W   = 2'h0;
    localparam logic [1:0] PINS_P1_2W   = 2'h2;
    localparam logic [1:0] PINS_P1_1W   = 2'h3;
    localparam logic [1:0] DMA_LIN_CODE = 2'h3;
    localparam logic       DIR_SEND     = 1'b0;
    localparam logic       CSUM_ENH     = 1'b0;
    localparam logic [3:0] LEN_ID0X     = 4'h2;
    localparam logic [3:0] LEN_ID10     = 4'h4;
    localparam logic [3:0] LEN_ID11     = 4'h8;
    localparam logic [7:0] CSUM_GOOD    = 8'hFF;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SYNC, ST_PID, ST_WAIT, ST_RESP, ST_WAKE
    } state_t;

endpackage

/* tb/lin_master_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Master node: sends headers and response bytes, idles recessive
// ----------------------------------------------------------------
module lin_master_model (
    input  wire logic sys_clk_i,
    output logic      bus_o
);
    localparam int BIT_CYC = 20;
    initial bus_o = 1'b1;
    // Hold a level for whole cycles; changes land just after falling edges
    task automatic hold(input logic lvl, input int n);
        bus_o = lvl;
        repeat (n) @(negedge sys_clk_i);
    endtask
    // One byte: start, eight data bits LSB first, stop
    task automatic send_byte(input logic [7:0] b);
        hold(1'b0, BIT_CYC);
        for (int i = 0; i < 8; i++) hold(b[i], BIT_CYC);
        hold(1'b1, BIT_CYC);
    endtask
    // Break outlasts eleven bits at the reset rate, so every header is seen
    task automatic header(input logic [5:0] id, input logic bad);
        hold(1'b0, 13300);
        hold(1'b1, BIT_CYC);
        send_byte(8'h55);
        send_byte({~(id[1] ^ id[3] ^ id[4] ^ id[5]) ^ bad, id[0] ^ id[1] ^ id[2] ^ id[4], id});
    endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, p01_i = 1'b1, p11_i, master_bus;
    logic controller_enable_i, sleep_select_i, interrupt_enable_bit_i, checksum_type_select_i;
    logic response_direction_i, length_from_identifier_i, readback_disable_i, dma_channel_select_i;
    logic header_acknowledge_i, frame_stop_i, wake_signal_bit_i, error_summary_clear_i;
    logic header_flag_clear_i, response_flag_clear_i, idle_flag_clear_i, wake_flag_clear_i;
    logic header_received_flag_o, response_complete_flag_o, bus_idle_flag_o, wake_signal_bit_o;
    logic readback_error_flag_o, sync_error_flag_o, identifier_error_flag_o, abort_flag_o;
    logic data_checksum_error_flag_o, error_summary_o, bus_active_o, irq_o, dma_write_o;
    logic p00_o, p00_oe_o, p10_o, p10_oe_o, p11_o, p11_oe_o;
    logic [1:0]  pin_mode_select_i, dma_ack_i = 2'h0, dma_req_o;
    logic [2:0]  dma_peripheral_select0_i, dma_peripheral_select1_i;
    logic [3:0]  response_size_i;
    logic [5:0]  received_identifier_o;
    logic [7:0]  dma_rdata_i, dma_wdata_o, sent, rx[$];
    logic [15:0] lin_baud_o;
    int          failures = 0, check_count = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    // Single wire with pull-up: either side pulls it low
    assign p11_i = master_bus & (p11_oe_o ? p11_o : 1'b1);
    lin_slave_controller #(.IDLE_CYCLES(200)) dut_u (.*);
    lin_master_model lin_master_u (.sys_clk_i(sys_clk_i), .bus_o(master_bus));
    // DMA side acknowledges each request once and keeps the written byte
    always @(negedge sys_clk_i) begin
        dma_ack_i <= dma_req_o & ~dma_ack_i;
        if (|(dma_req_o & ~dma_ack_i)) rx.push_back(dma_wdata_o);
    end
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait; a flag that never rises ends the run as a failure
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 20000 && s !== 1'b1; i++) @(negedge sys_clk_i);
        if (s !== 1'b1) begin
            failures++;
            conclude();
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk_i);
        s = 1'b0;
    endtask
    // Master side reads one byte the slave sends, sampled mid-bit at 20 cycles a bit
    task automatic take_byte(output logic [7:0] b);
        int i;
        for (i = 0; i < 4000 && p11_i !== 1'b0; i++) @(negedge sys_clk_i);
        repeat (10) @(negedge sys_clk_i);
        for (int k = 0; k < 8; k++) begin
            repeat (20) @(negedge sys_clk_i);
            b[k] = p11_i;
        end
        if (i == 4000) begin
            failures++;
            conclude();
        end
    endtask
    initial begin
        {sleep_select_i, checksum_type_select_i, readback_disable_i, dma_channel_select_i,
         header_acknowledge_i, frame_stop_i, wake_signal_bit_i, error_summary_clear_i,
         header_flag_clear_i, response_flag_clear_i, idle_flag_clear_i, wake_flag_clear_i} = '0;
        {controller_enable_i, interrupt_enable_bit_i, response_direction_i} = 3'h7;
        length_from_identifier_i = 1'b1;
        pin_mode_select_i = 2'h3;
        {dma_peripheral_select0_i, dma_peripheral_select1_i} = 6'h30;
        {response_size_i, dma_rdata_i} = 12'h000;
        repeat (6) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        chk(lin_baud_o, 16'h04AF);
        lin_master_u.header(6'h0A, 1'b0);
        wait_hi(header_received_flag_o);
        chk({received_identifier_o, lin_baud_o[9:0]}, {6'h0A, 10'h013});
        chk(irq_o, 1'b1);
        pulse(header_acknowledge_i);
        chk(header_received_flag_o, 1'b0);
        lin_master_u.send_byte(8'h3C);
        lin_master_u.send_byte(8'hC5);
        lin_master_u.send_byte(8'h33);
        wait_hi(response_complete_flag_o);
        chk({rx[0], rx[1]}, 16'h3CC5);
        chk(data_checksum_error_flag_o, 1'b0);
        wait_hi(bus_idle_flag_o);
        pulse(idle_flag_clear_i);
        sleep_select_i = 1'b1;
        lin_master_u.hold(1'b0, 1600);
        lin_master_u.hold(1'b1, 5);
        wait_hi(wake_signal_bit_o);
        pulse(wake_flag_clear_i);
        repeat (400) @(negedge sys_clk_i);
        chk(bus_idle_flag_o, 1'b0);
        {sleep_select_i, interrupt_enable_bit_i} = 2'h0;
        lin_master_u.header(6'h0A, 1'b1);
        wait_hi(identifier_error_flag_o);
        chk({header_received_flag_o,response_complete_flag_o,error_summary_o,irq_o},4'h2);
        pulse(error_summary_clear_i);
        chk({identifier_error_flag_o, error_summary_o}, 2'h0);
        lin_master_u.header(6'h0A, 1'b0);
        wait_hi(header_received_flag_o);
        pulse(frame_stop_i);
        chk(abort_flag_o, 1'b1);
        {response_direction_i, length_from_identifier_i, checksum_type_select_i} = 3'h1;
        {dma_channel_select_i, dma_peripheral_select1_i, response_size_i, dma_rdata_i} = 16'hE1A5;
        lin_master_u.header(6'h0A, 1'b0);
        wait_hi(header_received_flag_o);
        pulse(header_acknowledge_i);
        take_byte(sent);
        chk(sent, 8'hA5);
        take_byte(sent);
        chk(sent, 8'h5A);
        wait_hi(response_complete_flag_o);
        chk({readback_error_flag_o, dma_req_o}, 3'h0);
        pulse(wake_signal_bit_i);
        repeat (3) @(negedge sys_clk_i);
        chk(p11_i, 1'b0);
        repeat (4000) @(negedge sys_clk_i);
        chk({p11_i, sync_error_flag_o, bus_active_o}, 3'h4);
        conclude();
    end
endmodule
